//--- dsp_shift_defines.svh
// Constants for the DSP shift, bit-detect and flag block
`ifndef DSP_SHIFT_DEFINES_SVH
`define DSP_SHIFT_DEFINES_SVH

// Operand layout
`define ACC_WIDTH        40
`define ACC_MSB          39
`define BASE_MSB         31
`define UPPER_LSB        16
`define GUARD_LSB        32
`define WIDE_WIDTH       72
`define WIDE_MSB         71
`define WORD_WIDTH       16
`define WORD_MSB         15

// Shift amount fields
`define AMT_WIDTH        7
`define LAMT_WIDTH       6

// Condition-select codes
`define CS_CARRY         3'h0
`define CS_NEGATIVE      3'h1
`define CS_ZERO          3'h2
`define CS_OVERFLOW      3'h3
`define CS_GREATER       3'h4
`define CS_GREATER_EQ    3'h5

// Saturation values
`define SAT_POSITIVE     40'h00_7FFF_FFFF
`define SAT_NEGATIVE     40'hFF_8000_0000

// Bit-detect figures
`define DETECT_ALL_SIGN  6'h1F
`define DETECT_TOP_BIT   6'h1E
`define COUNT_MSB        6
`define DETECT_EXT       17
`define RESULT_RESET     40'h00_0000_0000

`endif

//--- dsp_shift_pkg.sv
// Types shared by the DSP shift and bit-detect block
package dsp_shift_pkg;
  typedef logic [39:0] acc_word_type;
  typedef logic [2:0]  cond_select_type;
  typedef enum logic [1:0] {
    op_idle,
    arith_shift_op,
    logic_shift_op,
    msb_detect_op
  } op_kind_type;
endpackage

//--- msb_detect_unit.sv
// Leading sign-bit counter for normalization shift counts
`timescale 1ns/1ps
`include "dsp_shift_defines.svh"

module msb_detect_unit
  import dsp_shift_pkg::*;
(
  // Operand
  input  wire acc_word_type      operand_in,
  // Signed count, -8 to +31
  output logic signed [6:0]      count_out
);

  logic [`ACC_MSB-1:0] differs;
  logic [5:0]          position;
  logic                found;

  // One comparator per bit against the guard sign
  genvar i;
  generate
    for (i = 0; i < `ACC_MSB; i++) begin : g_diff
      assign differs[i] = operand_in[i] ^ operand_in[`ACC_MSB];
    end
  endgenerate

  // Highest differing bit wins
  always_comb begin
    position = 6'h00;
    found    = 1'b0;
    for (int k = 0; k < `ACC_MSB; k++) begin
      if (differs[k]) begin
        position = 6'(k);
        found    = 1'b1;
      end
    end
    if (found) begin
      count_out = 7'(signed'({1'b0, `DETECT_TOP_BIT}) - signed'({1'b0, position}));
    end else begin
      count_out = 7'({1'b0, `DETECT_ALL_SIGN});
    end
  end

endmodule

//--- dsp_shift_msb_detect_flags.sv
// DSP shift, most-significant-bit detect and condition flag datapath
`timescale 1ns/1ps
`include "dsp_shift_defines.svh"

// What this block does
// (RULE1) Arith shift, overflow mode: flag shows overflow
// (RULE2) Arith shift, greater modes: flag cleared
// (RULE3) N, Z, V, GT mirror their mode's flag
// (RULE4) Saturation enable protects arith shift results
// (RULE5) Logical shift uses upper word only
// (RULE6) Logical amount valid -16 to +16
// (RULE7) Logical field -32..+31; out-of-range unspecified
// (RULE8) Immediate form reads source from destination
// (RULE9) Executes in the memory-access stage
// (RULE10) Conditional ops leave flags; unconditional update
// (RULE11) Logical carry mode: last bit out
// (RULE12) Logical negative mode: result bit 31
// (RULE13) Zero mode: flag set on zero result
// (RULE14) Logical shift clears V, GT, related modes
// (RULE15) Detect result 24 bits in upper part
// (RULE16) Detect scans all bits, integer result
// (RULE17) Detect carry and overflow modes: flag cleared
// (RULE18) Detect negative mode: set when negative
// (RULE19) Detect greater mode: set when strictly positive
// (RULE20) Detect greater-equal mode: set when not negative
// (RULE21) Detect count from bit 30, -8..+31
// (RULE22) Arith amount valid -32 to +32
// (RULE23) Arith shift is 40-bit, sign-extends source
// (RULE24) Arith carry mode: last bit out
// (RULE25) Saturation clears V and overflow-mode flag
module dsp_shift_msb_detect_flags
  import dsp_shift_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  // Operation issued into the memory-access stage
  input  wire logic              memory_access_stage_in,
  input  wire op_kind_type       op_kind_in,
  input  wire logic              conditional_in,
  input  wire logic              imm_form_in,
  // Operands
  input  wire acc_word_type      src1_in,
  input  wire logic              src1_has_guard_in,
  input  wire acc_word_type      dest_value_in,
  input  wire logic              dest_has_guard_in,
  input  wire logic [6:0]        amount_in,
  input  wire logic [6:0]        imm_amount_in,
  // Status and condition controls
  input  wire cond_select_type   cond_select_in,
  input  wire logic              cpu_status_register_sat_in,
  // Result
  output acc_word_type           result_out,
  output logic                   result_write_out,
  // Condition flags
  output logic                   selectable_condition_flag_out,
  output logic                   negative_flag_out,
  output logic                   zero_flag_out,
  output logic                   overflow_flag_out,
  output logic                   greater_flag_out
);

  // Operand selection
  acc_word_type             src_raw;
  logic                     src_guard;
  acc_word_type             src_full;
  logic [6:0]               amt;

  // Arithmetic shift path
  logic                     a_right;
  logic [6:0]               a_mag;
  logic [`WIDE_MSB:0]       a_wide;
  logic [`WIDE_MSB:0]       a_left;
  logic [`ACC_WIDTH:0]      a_rtmp;
  logic [`WIDE_MSB:0]       a_shifted;
  logic                     a_last;
  logic                     a_ovf;
  acc_word_type             a_result;
  logic                     a_neg;
  logic                     a_zero;
  logic                     a_vflag;
  logic                     a_dc;

  // Logical shift path
  logic signed [5:0]        l_amt;
  logic                     l_right;
  logic [5:0]               l_mag;
  logic [15:0]              l_src;
  logic [31:0]              l_ltmp;
  logic [16:0]              l_rtmp;
  logic [15:0]              l_word;
  logic                     l_last;
  acc_word_type             l_result;
  logic                     l_dc;

  // Bit-detect path
  logic signed [6:0]        d_count;
  logic [23:0]              d_value;
  acc_word_type             d_result;
  logic                     d_neg;
  logic                     d_zero;
  logic                     d_pos;
  logic                     d_dc;

  // Selected outcome
  acc_word_type             next_result;
  logic                     next_dc;
  logic                     next_neg;
  logic                     next_zero;
  logic                     next_ovf;
  logic                     next_gt;
  logic                     issue;
  logic                     flag_update;

  // Immediate form sources from the destination register
  always_comb begin
    if (imm_form_in) begin
      src_raw   = dest_value_in; // RULE8
      src_guard = dest_has_guard_in; // RULE8
      amt       = imm_amount_in;
    end else begin
      src_raw   = src1_in;
      src_guard = src1_has_guard_in;
      amt       = amount_in;
    end
  end

  // Sign-extend into guard bits when the source has none
  always_comb begin
    if (src_guard) begin
      src_full = src_raw;
    end else begin
      src_full = {{(`ACC_WIDTH-`GUARD_LSB){src_raw[`BASE_MSB]}}, src_raw[`BASE_MSB:0]}; // RULE23
    end
  end

  // Arithmetic shift: 40-bit data widened so overflow can be seen
  // Amounts beyond +-32 give an unspecified result, with no error raised
  // A zero amount shifts nothing out, so carry reads 0
  always_comb begin
    a_right = amt[`AMT_WIDTH-1]; // RULE22
    a_mag   = a_right ? 7'(-amt) : amt;
    a_wide  = {{(`WIDE_WIDTH-`ACC_WIDTH){src_full[`ACC_MSB]}}, src_full}; // RULE23
    a_left  = a_wide << a_mag;
    a_rtmp  = 41'($signed({src_full, 1'b0}) >>> a_mag);
    if (a_right) begin
      a_shifted = {{(`WIDE_WIDTH-`ACC_WIDTH){a_rtmp[`ACC_WIDTH]}}, a_rtmp[`ACC_WIDTH:1]};
      a_last    = a_rtmp[0]; // RULE24
    end else if (a_mag == 7'h00) begin
      a_shifted = a_wide;
      a_last    = 1'b0;
    end else begin
      a_shifted = a_left;
      a_last    = a_left[`ACC_WIDTH]; // RULE24
    end
  end

  // Overflow when the result leaves the guardless 32-bit range
  // Saturation also covers right shifts of large guard values
  always_comb begin
    a_ovf = ~((&a_shifted[`WIDE_MSB:`BASE_MSB]) | ~(|a_shifted[`WIDE_MSB:`BASE_MSB]));
    if (a_ovf && cpu_status_register_sat_in) begin
      if (a_shifted[`WIDE_MSB]) begin
        a_result = `SAT_NEGATIVE; // RULE4
      end else begin
        a_result = `SAT_POSITIVE; // RULE4
      end
      a_vflag = 1'b0; // RULE25
    end else begin
      a_result = a_shifted[`ACC_MSB:0];
      a_vflag  = a_ovf;
    end
    a_neg  = a_result[`ACC_MSB];
    a_zero = (a_result == `RESULT_RESET);
  end

  // Arithmetic shift selectable flag
  always_comb begin
    case (cond_select_in)
      `CS_CARRY:      a_dc = a_last; // RULE24
      `CS_NEGATIVE:   a_dc = a_neg;
      `CS_ZERO:       a_dc = a_zero; // RULE13
      `CS_OVERFLOW:   a_dc = a_vflag; // RULE1 RULE25
      `CS_GREATER:    a_dc = 1'b0; // RULE2
      `CS_GREATER_EQ: a_dc = 1'b0; // RULE2
      default:        a_dc = 1'b0;
    endcase
  end

  // Logical shift: upper word only, 6-bit signed amount
  // Amounts beyond +-16 give an unspecified word, with no error raised
  always_comb begin
    l_amt   = signed'(amt[`LAMT_WIDTH-1:0]); // RULE7
    l_right = l_amt[`LAMT_WIDTH-1]; // RULE6
    l_mag   = l_right ? 6'(-l_amt) : 6'(l_amt);
    l_src   = src_raw[`BASE_MSB:`UPPER_LSB]; // RULE5
    l_ltmp  = {16'h0000, l_src} << l_mag;
    l_rtmp  = {l_src, 1'b0} >> l_mag;
    if (l_right) begin
      l_word = l_rtmp[`WORD_WIDTH:1];
      l_last = l_rtmp[0]; // RULE11
    end else if (l_mag == 6'h00) begin
      l_word = l_src;
      l_last = 1'b0;
    end else begin
      l_word = l_ltmp[`WORD_MSB:0];
      l_last = l_ltmp[`WORD_WIDTH]; // RULE11
    end
    l_result = {8'h00, l_word, 16'h0000}; // RULE5
  end

  // Logical shift selectable flag
  // Overflow and greater modes never apply to a logical shift
  always_comb begin
    case (cond_select_in)
      `CS_CARRY:      l_dc = l_last; // RULE11
      `CS_NEGATIVE:   l_dc = l_result[`BASE_MSB]; // RULE12
      `CS_ZERO:       l_dc = (l_word == 16'h0000); // RULE13
      `CS_OVERFLOW:   l_dc = 1'b0; // RULE14
      `CS_GREATER:    l_dc = 1'b0; // RULE14
      `CS_GREATER_EQ: l_dc = 1'b0; // RULE14
      default:        l_dc = 1'b0;
    endcase
  end

  // Leading sign-bit count over the full operand
  msb_detect_unit u_detect (
    .operand_in (src_full), // RULE16
    .count_out  (d_count) // RULE21
  );

  // Count as 24-bit integer in the guard and upper word
  // Negative counts need the guard byte sign-extended
  always_comb begin
    d_value  = {{`DETECT_EXT{d_count[`COUNT_MSB]}}, d_count}; // RULE15
    d_result = {d_value, 16'h0000}; // RULE15 RULE16
    d_neg    = d_count[`COUNT_MSB];
    d_zero   = (d_count == 7'h00);
    d_pos    = ~d_neg & ~d_zero;
  end

  // Bit-detect selectable flag
  always_comb begin
    case (cond_select_in)
      `CS_CARRY:      d_dc = 1'b0; // RULE17
      `CS_NEGATIVE:   d_dc = d_neg; // RULE18
      `CS_ZERO:       d_dc = d_zero; // RULE13
      `CS_OVERFLOW:   d_dc = 1'b0; // RULE17
      `CS_GREATER:    d_dc = d_pos; // RULE19
      `CS_GREATER_EQ: d_dc = ~d_neg; // RULE20
      default:        d_dc = 1'b0;
    endcase
  end

  // Pick the outcome of the issued operation
  // Idle slot drives zeros; nothing is stored then
  always_comb begin
    case (op_kind_in)
      arith_shift_op: begin
        next_result = a_result;
        next_dc     = a_dc;
        next_neg    = a_neg; // RULE3
        next_zero   = a_zero; // RULE3
        next_ovf    = a_vflag; // RULE3 RULE25
        next_gt     = 1'b0; // RULE3
      end
      logic_shift_op: begin
        next_result = l_result;
        next_dc     = l_dc;
        next_neg    = l_result[`BASE_MSB]; // RULE3
        next_zero   = (l_word == 16'h0000); // RULE3
        next_ovf    = 1'b0; // RULE14
        next_gt     = 1'b0; // RULE14
      end
      msb_detect_op: begin
        next_result = d_result;
        next_dc     = d_dc;
        next_neg    = d_neg; // RULE3
        next_zero   = d_zero; // RULE3
        next_ovf    = 1'b0; // RULE3
        next_gt     = d_pos; // RULE3
      end
      default: begin
        next_result = `RESULT_RESET;
        next_dc     = 1'b0;
        next_neg    = 1'b0;
        next_zero   = 1'b0;
        next_ovf    = 1'b0;
        next_gt     = 1'b0;
      end
    endcase
  end

  // Work happens only in the memory-access stage slot
  assign issue       = memory_access_stage_in && (op_kind_in != op_idle); // RULE9

  // Conditional ops still write the result but hold the flags
  assign flag_update = issue && !conditional_in; // RULE10

  // Result register
  // Result holds until the next issued op
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= `RESULT_RESET;
    end else if (issue) begin
      result_out <= next_result; // RULE9
    end
  end

  // Write strobe, one cycle per issued operation
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result_write_out <= 1'b0;
    end else begin
      result_write_out <= issue; // RULE9
    end
  end

  // Selectable flag, meaning set by the condition select
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      selectable_condition_flag_out <= 1'b0;
    end else if (flag_update) begin
      selectable_condition_flag_out <= next_dc; // RULE10
    end
  end

  // Status flags hold across conditional operations
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      negative_flag_out             <= 1'b0;
      zero_flag_out                 <= 1'b0;
      overflow_flag_out             <= 1'b0;
      greater_flag_out              <= 1'b0;
    end else if (flag_update) begin
      negative_flag_out             <= next_neg; // RULE3
      zero_flag_out                 <= next_zero; // RULE3
      overflow_flag_out             <= next_ovf; // RULE3
      greater_flag_out              <= next_gt; // RULE3
    end
  end

endmodule

//--- dsp_shift_chk.sv
// Assertion checker for the shift, bit-detect and flag datapath
`timescale 1ns/1ps
`include "dsp_shift_defines.svh"
module dsp_shift_chk
  import dsp_shift_pkg::*;
(
  input wire logic            mclk_in,
  input wire logic            rst_in,
  input wire logic            memory_access_stage_in,
  input wire op_kind_type     op_kind_in,
  input wire logic            conditional_in,
  input wire cond_select_type cond_select_in,
  input wire logic            cpu_status_register_sat_in,
  input wire acc_word_type    result_out,
  input wire logic            result_write_out,
  input wire logic            selectable_condition_flag_out,
  input wire logic            negative_flag_out,
  input wire logic            zero_flag_out,
  input wire logic            overflow_flag_out,
  input wire logic            greater_flag_out
);
  wire       issue = memory_access_stage_in && op_kind_in != op_idle;
  wire       upd   = issue && !conditional_in;
  wire       sel   = selectable_condition_flag_out;
  wire [4:0] flg   = {sel, negative_flag_out, zero_flag_out, overflow_flag_out, greater_flag_out};
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_write_on_issue: assert property (issue |=> result_write_out)
    else $error("no write one cycle after issue");
  a_no_idle_write: assert property (!issue |=> !result_write_out)
    else $error("write without issue");
  a_cond_keeps_flags: assert property (issue && conditional_in |=> $stable(flg))
    else $error("conditional op changed flags");
  a_mirror_negative: assert property (
    upd && cond_select_in == `CS_NEGATIVE |=> sel == negative_flag_out)
    else $error("selectable flag differs from negative flag");
  a_mirror_zero: assert property (
    upd && cond_select_in == `CS_ZERO |=> sel == zero_flag_out)
    else $error("selectable flag differs from zero flag");
  a_mirror_overflow: assert property (
    upd && cond_select_in == `CS_OVERFLOW |=> sel == overflow_flag_out)
    else $error("selectable flag differs from overflow flag");
  a_mirror_greater: assert property (
    upd && cond_select_in == `CS_GREATER |=> sel == greater_flag_out)
    else $error("selectable flag differs from greater flag");
  a_logic_clears_vg: assert property (
    upd && op_kind_in == logic_shift_op |=> !overflow_flag_out && !greater_flag_out)
    else $error("logical shift left overflow or greater set");
  a_logic_word_only: assert property (
    issue && op_kind_in == logic_shift_op
    |=> result_out[15:0] == 16'h0000 && result_out[39:32] == 8'h00)
    else $error("logical shift lower word or guard not cleared");
  a_arith_gt_clear: assert property (
    upd && op_kind_in == arith_shift_op
    && cond_select_in inside {`CS_GREATER, `CS_GREATER_EQ} |=> !sel)
    else $error("arith shift set flag in greater mode");
  a_sat_clears_v: assert property (
    upd && op_kind_in == arith_shift_op && cpu_status_register_sat_in |=> !overflow_flag_out)
    else $error("overflow flag set with saturation on");
  a_detect_sel_clear: assert property (
    upd && op_kind_in == msb_detect_op
    && cond_select_in inside {`CS_CARRY, `CS_OVERFLOW} |=> !sel && !overflow_flag_out)
    else $error("detect set flag in carry or overflow mode");
  a_detect_low_zero: assert property (
    issue && op_kind_in == msb_detect_op |=> result_out[15:0] == 16'h0000)
    else $error("detect result lower word not zero");
endmodule
bind dsp_shift_msb_detect_flags dsp_shift_chk u_chk (.*);

//--- dsp_reg_model.sv
// Destination register of the DSP register file
`timescale 1ns/1ps
module dsp_reg_model
  import dsp_shift_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wire logic         write_in,
  input  wire logic         has_guard_in,
  input  wire acc_word_type value_in,
  output acc_word_type      reg_out
);
  // Register without guard keeps only the low 32 bits
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_out <= 40'h00_0000_0000;
    end else if (write_in) begin
      reg_out <= has_guard_in ? value_in : {8'h00, value_in[31:0]};
    end
  end
endmodule

//--- tb_dsp_shift_msb_detect_flags.sv
// Testbench for the shift, bit-detect and flag datapath
`timescale 1ns/1ps
`include "dsp_shift_defines.svh"
module tb_dsp_shift_msb_detect_flags
  import dsp_shift_pkg::*;
;
  logic mclk_in = 0, rst_in = 1, stage = 0, cond = 0, imm = 0, sg = 0, dg = 0, sat = 0;
  op_kind_type op = op_idle;
  acc_word_type src = 0, dval = 0, res, rg, e_res;
  logic [6:0] amt = 0, iamt = 0;
  logic [2:0] cs = 0;
  logic sel, fn, fz, fv, fg, wr;
  logic [4:0] e_f;
  int n_mismatch = 0, checks = 0, cycles = 0;
  // Vector: op, source guard, saturation, amount, source
  logic [50:0] vecs [13] = '{
    {2'h1, 1'h1, 1'h0, 7'h04, 40'h00_1234_5678}, {2'h1, 1'h1, 1'h1, 7'h04, 40'h00_1234_5678},
    {2'h1, 1'h1, 1'h0, 7'h60, 40'hF0_8000_0001}, {2'h1, 1'h0, 1'h0, 7'h20, 40'h00_8000_0000},
    {2'h1, 1'h1, 1'h1, 7'h00, 40'h00_0000_0003}, {2'h2, 1'h1, 1'h0, 7'h10, 40'hAB_F00F_1234},
    {2'h2, 1'h1, 1'h0, 7'h30, 40'hAB_F00F_1234}, {2'h2, 1'h0, 1'h0, 7'h01, 40'h00_8001_0000},
    {2'h3, 1'h1, 1'h0, 7'h00, 40'h00_0000_0000}, {2'h3, 1'h1, 1'h0, 7'h00, 40'h80_0000_0000},
    {2'h3, 1'h1, 1'h0, 7'h00, 40'h00_4000_0000}, {2'h3, 1'h0, 1'h0, 7'h00, 40'h00_0000_0001},
    {2'h3, 1'h0, 1'h0, 7'h00, 40'h00_FFFF_F000}};
  dsp_shift_msb_detect_flags u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .memory_access_stage_in(stage), .op_kind_in(op), .conditional_in(cond),
    .imm_form_in(imm), .src1_in(src), .src1_has_guard_in(sg), .dest_value_in(dval),
    .dest_has_guard_in(dg), .amount_in(amt), .imm_amount_in(iamt), .cond_select_in(cs),
    .cpu_status_register_sat_in(sat), .result_out(res), .result_write_out(wr),
    .selectable_condition_flag_out(sel), .negative_flag_out(fn), .zero_flag_out(fz),
    .overflow_flag_out(fv), .greater_flag_out(fg));
  dsp_reg_model u_reg (.mclk_in(mclk_in), .rst_in(rst_in), .write_in(wr),
    .has_guard_in(dg), .value_in(res), .reg_out(rg));
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic calc(input logic [50:0] v, input logic [2:0] c);
    logic signed [79:0] w;
    logic signed [39:0] x;
    logic [31:0] t;
    logic [15:0] wd;
    logic [23:0] c24;
    int a, i, cnt;
    logic lo, ov, n, z;
    x = v[48] ? v[39:0] : {{8{v[31]}}, v[31:0]};
    lo = 0;
    ov = 0;
    cnt = 0;
    if (v[50:49] == 2'h1) begin
      a = $signed(v[46:40]);
      w = x;
      if (a >= 0) begin
        w = w <<< a;
        if (a > 0) lo = x[40 - a];
      end else begin
        w = w >>> -a;
        lo = x[-a - 1];
      end
      ov = w > 64'sd2147483647 || w < -64'sd2147483648;
      e_res = w[39:0];
      if (ov && v[47]) e_res = w < 0 ? `SAT_NEGATIVE : `SAT_POSITIVE;
      ov = ov && !v[47];
    end else if (v[50:49] == 2'h2) begin
      a = $signed(v[45:40]);
      if (a >= 0) begin
        t = {16'h0000, v[31:16]} << a;
        wd = t[15:0];
        lo = a > 0 ? t[16] : 1'b0;
      end else begin
        t = {v[31:16], 16'h0000} >> -a;
        wd = t[31:16];
        lo = t[15];
      end
      e_res = {8'h00, wd, 16'h0000};
    end else begin
      cnt = 31;
      for (i = 0; i < 39; i++) if (x[i] != x[39]) cnt = 30 - i;
      c24 = cnt[23:0];
      e_res = {c24, 16'h0000};
    end
    n = v[50:49] == 2'h3 ? cnt < 0 : v[50:49] == 2'h2 ? e_res[31] : e_res[39];
    z = e_res == 40'h00_0000_0000;
    e_f[3:0] = {n, z, ov, v[50:49] == 2'h3 && cnt > 0};
    case (c)
      3'h0: e_f[4] = v[50:49] == 2'h3 ? 1'b0 : lo;
      3'h1: e_f[4] = n;
      3'h2: e_f[4] = z;
      3'h3: e_f[4] = ov;
      3'h4: e_f[4] = e_f[0];
      3'h5: e_f[4] = v[50:49] == 2'h3 && cnt >= 0;
      default: e_f[4] = 1'b0;
    endcase
  endtask
  task automatic run(input logic [50:0] v, input logic [2:0] c, input logic cn, input logic im);
    logic [4:0] old;
    old = {sel, fn, fz, fv, fg};
    calc(v, c);
    if (cn) e_f = old;
    @(posedge mclk_in);
    #1;
    stage = 1'b1;
    op = op_kind_type'(v[50:49]);
    cond = cn;
    imm = im;
    sat = v[47];
    cs = c;
    {src, sg, amt} = im ? {~v[39:0], ~v[48], 7'h00} : {v[39:0], v[48], v[46:40]};
    {dval, dg, iamt} = im ? {v[39:0], v[48], v[46:40]} : {~v[39:0], ~v[48], 7'h00};
    @(posedge mclk_in);
    #1;
    stage = 0;
    chk("write", {39'h0, wr}, 40'h1);
    chk("result", res, e_res);
    chk("flags", {35'h0, sel, fn, fz, fv, fg}, {35'h0, e_f});
    @(posedge mclk_in);
    #1;
    chk("dest", rg, dg ? e_res : {8'h00, e_res[31:0]});
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge mclk_in);
    #1;
    rst_in = 0;
    @(posedge mclk_in);
    #1;
    chk("reset result", res, 40'h00_0000_0000);
    chk("reset flags", {34'h0, wr, sel, fn, fz, fv, fg}, 40'h00_0000_0000);
    for (int i = 0; i < 13; i++) begin
      for (int c = 0; c < 8; c++) run(vecs[i], c[2:0], 1'b0, i[0]);
    end
    run(vecs[9], 3'h1, 1'b1, 1'b0);
    run(vecs[3], 3'h3, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule
